// ===== hdl/pscp_pkg.sv
package pscp_pkg;

    // clock rate and programming cycle timing
    localparam int unsigned CLK_MHZ          = 125;
    localparam int unsigned NV_PROG_TIME_NS  = 1000000;
    localparam int unsigned NV_PROG_CYCLES   = (NV_PROG_TIME_NS * CLK_MHZ + 999) / 1000;

    // slave address: fixed upper bits, then two bits per address select pin
    localparam logic [2:0] ADDR_BASE         = 3'h2;
    localparam logic [1:0] SEL_LOW           = 2'h0;
    localparam logic [1:0] SEL_HIGH          = 2'h1;
    localparam logic [1:0] SEL_FLOAT         = 2'h2;

    // instruction and address byte fields
    localparam int unsigned CMD_MSB          = 7;
    localparam int unsigned CMD_LSB          = 5;
    localparam int unsigned PTR_MSB          = 4;
    localparam int unsigned RW_BIT           = 0;
    localparam int unsigned WP_BIT           = 0;

    // pointer locations
    localparam logic [4:0] PTR_WIPER_SAVE    = 5'h00;
    localparam logic [4:0] PTR_TOL_INT       = 5'h1E;
    localparam logic [4:0] PTR_TOL_FRAC      = 5'h1F;
    localparam int unsigned NV_WORDS         = 30;

    // reset and factory values
    localparam logic [7:0] WIPER_RESET       = 8'h80;
    localparam logic       WPROT_RESET       = 1'b0;
    localparam logic [4:0] PTR_RESET         = 5'h00;
    localparam logic [7:0] NV_RESET          = 8'h00;
    localparam logic [7:0] TOL_INT_DEFAULT   = 8'h00;
    localparam logic [7:0] TOL_FRAC_DEFAULT  = 8'h00;

    // command codes carried in the top three bits of the instruction byte
    typedef enum logic [2:0] {
        CMD_WIPER_WR = 3'h0,
        CMD_NV_WR    = 3'h1,
        CMD_WPROT    = 3'h2,
        CMD_TOL_RD   = 3'h3,
        CMD_WIPER_RD = 3'h4,
        CMD_NV_RD    = 3'h5,
        CMD_STORE    = 3'h6,
        CMD_RESTORE  = 3'h7
    } pscp_cmd_e;

    typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK} pscp_state_e;
    typedef enum logic [1:0] {K_ADDR, K_INSTR, K_DATA} pscp_kind_e;

    // maps one three-state select pin to two address bits
    function automatic logic [1:0] pscp_sel_bits(input logic [1:0] sel);
        pscp_sel_bits = (sel == SEL_LOW) ? SEL_LOW : ((sel == SEL_HIGH) ? SEL_HIGH : SEL_FLOAT);
    endfunction : pscp_sel_bits

endpackage : pscp_pkg

// ===== hdl/pscp_if.sv
`timescale 1ns/1ps

// conditioned bus line events from the synchroniser
interface pscp_line_if;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda;
    logic       start;
    logic       stop;
    logic [1:0] sel0;
    logic [1:0] sel1;
    modport src (output scl_rise, scl_fall, sda, start, stop, sel0, sel1);
    modport dst (input  scl_rise, scl_fall, sda, start, stop, sel0, sel1);
endinterface : pscp_line_if

// nonvolatile store access
interface pscp_nv_if;
    logic       wr;
    logic [4:0] wr_ptr;
    logic [7:0] wr_data;
    logic [4:0] rd_ptr;
    logic [7:0] rd_data;
    logic [7:0] save_data;
    logic       busy;
    modport store (input  wr, wr_ptr, wr_data, rd_ptr, output rd_data, save_data, busy);
    modport user  (output wr, wr_ptr, wr_data, rd_ptr, input  rd_data, save_data, busy);
endinterface : pscp_nv_if

// ===== hdl/pscp_line_sync.sv
`timescale 1ns/1ps

module pscp_line_sync
    import pscp_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [1:0] addr_select_pin_0_i,
    input  wire logic [1:0] addr_select_pin_1_i,
    pscp_line_if.src        line
);

    typedef struct packed {
        logic       scl_m;
        logic       scl_s;
        logic       scl_d;
        logic       sda_m;
        logic       sda_s;
        logic       sda_d;
        logic [1:0] sel0_m;
        logic [1:0] sel0_s;
        logic [1:0] sel1_m;
        logic [1:0] sel1_s;
    } pscp_sync_s;

    pscp_sync_s s;
    pscp_sync_s next_s;

    // two flops per pin, then a delayed copy of scl and sda for edge finding
    always_comb
    begin
        next_s        = s;
        next_s.scl_m  = scl_i;
        next_s.scl_s  = s.scl_m;
        next_s.scl_d  = s.scl_s;
        next_s.sda_m  = sda_i;
        next_s.sda_s  = s.sda_m;
        next_s.sda_d  = s.sda_s;
        next_s.sel0_m = addr_select_pin_0_i;
        next_s.sel0_s = s.sel0_m;
        next_s.sel1_m = addr_select_pin_1_i;
        next_s.sel1_s = s.sel1_m;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= '{scl_m: 1'b1, scl_s: 1'b1, scl_d: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
                   sda_d: 1'b1, sel0_m: SEL_LOW, sel0_s: SEL_LOW, sel1_m: SEL_LOW,
                   sel1_s: SEL_LOW};
        else
            s <= next_s;
    end

    // start is sda falling with scl high, stop is sda rising with scl high
    assign line.scl_rise = s.scl_s & ~s.scl_d;
    assign line.scl_fall = ~s.scl_s & s.scl_d;
    assign line.sda      = s.sda_s;
    assign line.start    = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
    assign line.stop     = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
    assign line.sel0     = s.sel0_s;
    assign line.sel1     = s.sel1_s;

endmodule : pscp_line_sync

// ===== hdl/pscp_nv_store.sv
`timescale 1ns/1ps

module pscp_nv_store
    import pscp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = NV_PROG_CYCLES,
    parameter logic [7:0]  TOL_INT     = TOL_INT_DEFAULT,
    parameter logic [7:0]  TOL_FRAC    = TOL_FRAC_DEFAULT
)
(
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    pscp_nv_if.store        nv
);

    typedef struct packed {
        logic [NV_WORDS-1:0][7:0] mem;
        logic                     busy;
        logic [31:0]              cnt;
    } pscp_nv_s;

    pscp_nv_s s;
    pscp_nv_s next_s;

    // a write lands at once, then the programming cycle holds busy
    always_comb
    begin
        next_s = s;
        if (s.busy)
        begin
            if (s.cnt == 32'h0)
                next_s.busy = 1'b0;
            else
                next_s.cnt = s.cnt - 32'h1;
        end
        else if (nv.wr)
        begin
            next_s.mem[nv.wr_ptr] = nv.wr_data;
            next_s.busy           = 1'b1;
            next_s.cnt            = PROG_CYCLES - 1;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= '{mem: '0, busy: 1'b0, cnt: 32'h0};
        else
            s <= next_s;
    end

    // factory tolerance bytes sit above the writable words
    assign nv.rd_data   = (nv.rd_ptr == PTR_TOL_INT)  ? TOL_INT :
                          (nv.rd_ptr == PTR_TOL_FRAC) ? TOL_FRAC :
                          s.mem[nv.rd_ptr];
    assign nv.save_data = s.mem[PTR_WIPER_SAVE];
    assign nv.busy      = s.busy;

endmodule : pscp_nv_store

// ===== hdl/pscp_serial_port.sv
// Overview of operation
// - nonvolatile write starts programming, port goes deaf
// - polling address acknowledged only after programming
// - start is sda falling while scl high
// - address byte ends in direction bit, high reads
// - two three-state select pins form address bits
// - matching address acknowledged low on ninth clock
// - unmatched device stays off the data line
// - write: instruction byte, then optional data byte
// - top three bits command, low five pointer
// - bytes travel most significant bit first
// - write protect takes data bit zero only
// - store and restore carry no data byte
// - store saves wiper, restore reloads wiper
// - read returns wiper, store word or tolerance
// - tolerance bytes readable together or singly
// - stop is sda rising while scl high
// - every further data byte of a wiper write updates wiper
// - new instruction needs new transaction; repeat reads
// - tolerance pointer steps from first to second
// - tolerance: sign, integer byte, fraction byte
`timescale 1ns/1ps

module pscp_serial_port
    import pscp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = NV_PROG_CYCLES,
    parameter logic [7:0]  TOL_INT     = TOL_INT_DEFAULT,
    parameter logic [7:0]  TOL_FRAC    = TOL_FRAC_DEFAULT
)
(
    input  wire logic       core_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output      logic       sda_o,
    output      logic       sda_oe_o,
    input  wire logic [1:0] addr_select_pin_0_i,
    input  wire logic [1:0] addr_select_pin_1_i,
    output      logic [7:0] wiper_setting_register_o,
    output      logic       write_protect_o,
    output      logic       prog_busy_o
);

    typedef struct packed {
        pscp_state_e state;
        pscp_kind_e  kind;
        logic [2:0]  cnt;
        logic        got;
        logic [7:0]  shreg;
        logic [7:0]  txreg;
        logic        rw;
        pscp_cmd_e   cmd;
        logic [4:0]  ptr;
        logic [7:0]  wiper;
        logic        wprot;
        logic        oe;
        logic        drv;
        logic        nv_wr;
        logic [4:0]  nv_ptr;
        logic [7:0]  nv_data;
        logic        busy;
    } pscp_core_s;

    pscp_core_s s;
    pscp_core_s next_s;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;

    pscp_line_if line ();
    pscp_nv_if   nv ();

    // pin conditioning and event detection
    pscp_line_sync u_sync (
        .core_clk_i          (core_clk_i),
        .resetn_i            (resetn_i),
        .scl_i               (scl_i),
        .sda_i               (sda_i),
        .addr_select_pin_0_i (addr_select_pin_0_i),
        .addr_select_pin_1_i (addr_select_pin_1_i),
        .line                (line.src)
    );

    // nonvolatile words, tolerance bytes and programming timer
    pscp_nv_store #(
        .PROG_CYCLES (PROG_CYCLES),
        .TOL_INT     (TOL_INT),
        .TOL_FRAC    (TOL_FRAC)
    ) u_nv (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .nv         (nv.store)
    );

    // picks the byte a read returns for the command in force
    function automatic logic [7:0] pscp_pick(input pscp_cmd_e cmd, input logic [7:0] wiper,
                                             input logic [7:0] nv_word);
        unique case (cmd)
            CMD_NV_WR,
            CMD_TOL_RD,
            CMD_NV_RD: pscp_pick = nv_word;
            CMD_WIPER_WR,
            CMD_WPROT,
            CMD_WIPER_RD,
            CMD_STORE,
            CMD_RESTORE: pscp_pick = wiper;
        endcase
    endfunction : pscp_pick

    // own address from the fixed bits and both select pins
    assign own_addr = {ADDR_BASE, pscp_sel_bits(line.sel1), pscp_sel_bits(line.sel0)};
    assign rd_byte  = pscp_pick(s.cmd, s.wiper, nv.rd_data);

    // requests towards the nonvolatile store
    assign nv.wr      = s.nv_wr;
    assign nv.wr_ptr  = s.nv_ptr;
    assign nv.wr_data = s.nv_data;
    assign nv.rd_ptr  = s.ptr;

    // byte level protocol engine
    always_comb
    begin
        next_s       = s;
        next_s.nv_wr = 1'b0;
        next_s.busy  = nv.busy;
        if (line.stop)
        begin
            next_s.state = ST_IDLE;
            next_s.oe    = 1'b0;
        end
        else if (line.start)
        begin
            next_s.state = ST_RECV;
            next_s.kind  = K_ADDR;
            next_s.cnt   = 3'h0;
            next_s.got   = 1'b0;
            next_s.oe    = 1'b0;
        end
        else
        begin
            unique case (s.state)
                ST_IDLE:
                begin
                    next_s.oe = 1'b0;
                end
                ST_RECV:
                begin
                    if (line.scl_rise)
                    begin
                        next_s.shreg = {s.shreg[6:0], line.sda};
                        next_s.cnt   = 3'(s.cnt + 3'h1);
                        next_s.got   = (s.cnt == 3'h7);
                    end
                    else if (line.scl_fall && s.got)
                    begin
                        next_s.got   = 1'b0;
                        next_s.state = ST_IDLE;
                        unique case (s.kind)
                            K_ADDR:
                            begin
                                // busy programming leaves even a match unanswered
                                if (s.shreg[7:1] == own_addr && !s.busy)
                                begin
                                    next_s.rw    = s.shreg[RW_BIT];
                                    next_s.kind  = K_INSTR;
                                    next_s.oe    = 1'b1;
                                    next_s.state = ST_ACK;
                                end
                            end
                            K_INSTR:
                            begin
                                next_s.cmd = pscp_cmd_e'(s.shreg[CMD_MSB:CMD_LSB]);
                                next_s.ptr   = s.shreg[PTR_MSB:0];
                                next_s.kind  = K_DATA;
                                next_s.oe    = 1'b1;
                                next_s.state = ST_ACK;
                                if (pscp_cmd_e'(s.shreg[CMD_MSB:CMD_LSB]) == CMD_STORE
                                    && !s.wprot)
                                begin
                                    next_s.nv_wr   = 1'b1;
                                    next_s.nv_ptr  = PTR_WIPER_SAVE;
                                    next_s.nv_data = s.wiper;
                                end
                                if (pscp_cmd_e'(s.shreg[CMD_MSB:CMD_LSB]) == CMD_RESTORE)
                                    next_s.wiper = nv.save_data;
                            end
                            K_DATA:
                            begin
                                // once programming runs, further bytes are refused
                                if (!s.busy && !s.nv_wr)
                                begin
                                    unique case (s.cmd)
                                        CMD_WIPER_WR:
                                        begin
                                            next_s.wiper = s.shreg;
                                            next_s.oe    = 1'b1;
                                            next_s.state = ST_ACK;
                                        end
                                        CMD_NV_WR:
                                        begin
                                            if (!s.wprot && s.ptr < 5'(NV_WORDS))
                                            begin
                                                next_s.nv_wr   = 1'b1;
                                                next_s.nv_ptr  = s.ptr;
                                                next_s.nv_data = s.shreg;
                                                next_s.oe      = 1'b1;
                                                next_s.state   = ST_ACK;
                                            end
                                        end
                                        CMD_WPROT:
                                        begin
                                            next_s.wprot = s.shreg[WP_BIT];
                                            next_s.oe    = 1'b1;
                                            next_s.state = ST_ACK;
                                        end
                                        CMD_TOL_RD,
                                        CMD_WIPER_RD,
                                        CMD_NV_RD,
                                        CMD_STORE,
                                        CMD_RESTORE:
                                        begin
                                            next_s.state = ST_IDLE;
                                        end
                                    endcase
                                end
                            end
                            default:
                            begin
                                next_s.state = ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    // acknowledge slot ends on the falling clock
                    if (line.scl_fall)
                    begin
                        next_s.cnt = 3'h0;
                        if (s.rw && s.kind == K_INSTR)
                        begin
                            next_s.txreg = rd_byte;
                            next_s.oe    = ~rd_byte[7];
                            next_s.state = ST_SEND;
                        end
                        else
                        begin
                            next_s.oe    = 1'b0;
                            next_s.state = ST_RECV;
                        end
                    end
                end
                ST_SEND:
                begin
                    if (line.scl_fall)
                    begin
                        if (s.cnt == 3'h7)
                        begin
                            next_s.oe    = 1'b0;
                            next_s.state = ST_MACK;
                        end
                        else
                        begin
                            next_s.cnt   = 3'(s.cnt + 3'h1);
                            next_s.txreg = {s.txreg[6:0], 1'b0};
                            next_s.oe    = ~s.txreg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (line.scl_rise)
                    begin
                        if (line.sda)
                            next_s.state = ST_IDLE;
                        else if (s.ptr == PTR_TOL_INT)
                            next_s.ptr = PTR_TOL_FRAC;
                    end
                    else if (line.scl_fall)
                    begin
                        // master acknowledged: send the next byte, wiper reads repeat
                        next_s.cnt   = 3'h0;
                        next_s.txreg = rd_byte;
                        next_s.oe    = ~rd_byte[7];
                        next_s.state = ST_SEND;
                    end
                end
                default:
                begin
                    next_s.state = ST_IDLE;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= '{state: ST_IDLE, kind: K_ADDR, cnt: 3'h0, got: 1'b0, shreg: 8'h00,
                   txreg: 8'h00, rw: 1'b0, cmd: CMD_WIPER_WR, ptr: PTR_RESET,
                   wiper: WIPER_RESET, wprot: WPROT_RESET, oe: 1'b0, drv: 1'b0,
                   nv_wr: 1'b0, nv_ptr: PTR_RESET, nv_data: NV_RESET, busy: 1'b0};
        else
            s <= next_s;
    end

    // outputs straight from the state register
    assign sda_o                    = s.drv;
    assign sda_oe_o                 = s.oe;
    assign wiper_setting_register_o = s.wiper;
    assign write_protect_o          = s.wprot;
    assign prog_busy_o              = s.busy;

endmodule : pscp_serial_port

// ===== dv/pscp_sva.sv
`timescale 1ns/1ps
// pin level checks of the serial port
module pscp_sva
    import pscp_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = NV_PROG_CYCLES
)
(
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic       scl_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic [7:0] wiper_setting_register_o,
    input wire logic       write_protect_o,
    input wire logic       prog_busy_o
);
    default clocking dck @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    int unsigned busy_cnt;
    // counts the cycles of the running programming cycle
    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            busy_cnt <= 0;
        else
            busy_cnt <= prog_busy_o ? busy_cnt + 1 : 0;
    // a pulled bit stays pulled for at least eight core cycles
    sequence held_s;
        sda_oe_o [*8];
    endsequence
    // programming starts inside an acknowledge, then runs on
    sequence prog_s;
        (sda_oe_o && prog_busy_o) ##1 prog_busy_o [*7];
    endsequence
    od_low_a: assert property (!sda_o) else $error("sda driven high");
    oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda moved with scl high");
    oe_hold_a: assert property ($rose(sda_oe_o) |-> held_s)
        else $error("sda pulse short");
    prog_run_a: assert property ($rose(prog_busy_o) |-> prog_s)
        else $error("programming start wrong");
    prog_len_a: assert property ($fell(prog_busy_o) |-> busy_cnt == PROG_CYCLES)
        else $error("programming length wrong");
    poll_nak_a: assert property ($rose(sda_oe_o) |-> !prog_busy_o)
        else $error("ack while programming");
    wiper_upd_a: assert property (
        $changed(wiper_setting_register_o) |-> !scl_i && !prog_busy_o)
        else $error("wiper moved at wrong time");
    wprot_upd_a: assert property (
        $changed(write_protect_o) |-> !scl_i && !prog_busy_o)
        else $error("protect moved at wrong time");
endmodule : pscp_sva
bind pscp_serial_port pscp_sva #(.PROG_CYCLES(PROG_CYCLES)) pscp_sva_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .wiper_setting_register_o(wiper_setting_register_o),
    .write_protect_o(write_protect_o), .prog_busy_o(prog_busy_o));

// ===== dv/pscp_master.sv
`timescale 1ns/1ps
// bus master model: drives the clock, pulls data low or releases it to the pull-up
module pscp_master
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output      logic scl_o,
    output      logic sda_low_o
);
    // idle bus: both lines stand high
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    // a quarter of the 160 ns serial period
    task automatic q4();
        repeat (5) @(negedge clk_i);
    endtask : q4
    // data pulled low if b0, clock high, data pulled low if b1, clock ends at fin
    task automatic cond(input logic b0, input logic b1, input logic fin);
        sda_low_o = b0;
        q4();
        scl_o = 1'b1;
        q4();
        sda_low_o = b1;
        q4();
        scl_o = fin;
        q4();
    endtask : cond
    // one bit slot, sampled in the middle of clock high
    task automatic bit_io(input logic b, output logic r);
        sda_low_o = !b;
        q4();
        scl_o = 1'b1;
        q4();
        r = sda_i;
        q4();
        scl_o = 1'b0;
        q4();
    endtask : bit_io
    // eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                        output logic ak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(a, ak);
    endtask : xfer
endmodule : pscp_master

// ===== dv/pot_serial_command_port_tb_top.sv
`timescale 1ns/1ps
module pot_serial_command_port_tb_top
    import pscp_pkg::*;
;
    localparam logic [7:0] TI = 8'h9C;
    localparam logic [7:0] TF = 8'h0F;
    logic       clk  = 1'b0;
    logic       rstn = 1'b0;
    logic       scl, sdal, sdo, oe, wp, busy, ak;
    logic [1:0] s0, s1;
    logic [6:0] me;
    logic [7:0] wip, q, d;
    logic [4:0] p;
    int         error_cnt = 0;
    int         checks    = 0;
    int         seed      = 32'h1086;
    int         m_wip     = 128;
    int         nv [32];
    wire        sda = !(oe || sdal);  // open-drain line with pull-up
    always #4 clk = !clk;
    pscp_serial_port #(.PROG_CYCLES(400), .TOL_INT(TI), .TOL_FRAC(TF)) pscp_serial_port_inst (
        .core_clk_i(clk), .resetn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
        .sda_oe_o(oe), .addr_select_pin_0_i(s0), .addr_select_pin_1_i(s1),
        .wiper_setting_register_o(wip), .write_protect_o(wp), .prog_busy_o(busy));
    pscp_master pscp_master_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sdal));
    // verdict and end of run
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // start, address byte and its acknowledge level
    task automatic adr(input logic rd, input logic nak);
        pscp_master_inst.cond(1'b0, 1'b1, 1'b0);
        pscp_master_inst.xfer({me, rd}, 1'b1, q, ak);
        chk({7'h0, ak}, {7'h0, nak});
    endtask : adr
    task automatic wb(input logic [7:0] v, input logic nak);
        pscp_master_inst.xfer(v, 1'b1, q, ak);
        chk({7'h0, ak}, {7'h0, nak});
    endtask : wb
    task automatic rb(input logic [7:0] e, input logic last);
        pscp_master_inst.xfer(8'hFF, last, q, ak);
        chk(q, e);
    endtask : rb
    // address and instruction of a write transfer
    task automatic sr(input logic [7:0] v);
        adr(1'b0, 1'b0);
        wb(v, 1'b0);
    endtask : sr
    // polling: first try refused, then retried until answered
    task automatic poll();
        int n;
        n = 0;
        adr(1'b0, 1'b1);
        while (ak === 1'b1 && n < 30)
        begin
            pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
            pscp_master_inst.cond(1'b0, 1'b1, 1'b0);
            pscp_master_inst.xfer({me, 1'b0}, 1'b1, q, ak);
            n++;
        end
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        if (n == 30)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask : poll
    // main sequence
    initial
    begin
        d = 8'($random(seed));
        s0 = d[1:0];
        s1 = d[3:2];
        me = {ADDR_BASE, (s1 == 2'h3) ? SEL_FLOAT : s1, (s0 == 2'h3) ? SEL_FLOAT : s0};
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        chk(wip, WIPER_RESET);
        me = me ^ 7'h40;
        adr(1'b0, 1'b1);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        me = me ^ 7'h40;
        sr({CMD_WIPER_WR, 5'h00});
        repeat (3)
        begin
            d = 8'($random(seed));
            wb(d, 1'b0);
            m_wip = d;
            chk(wip, 8'(m_wip));
        end
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        adr(1'b1, 1'b0);
        rb(8'(m_wip), 1'b0);
        rb(8'(m_wip), 1'b1);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        p = 5'(1 + ($random(seed) & 15));
        d = 8'($random(seed));
        sr({CMD_NV_WR, p});
        wb(d, 1'b0);
        nv[p] = d;
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        chk({7'h0, busy}, 8'h01);
        poll();
        adr(1'b1, 1'b0);
        rb(8'(nv[p]), 1'b1);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        sr({CMD_WPROT, 5'h00});
        wb(d | 8'h01, 1'b0);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        chk({7'h0, wp}, 8'h01);
        sr({CMD_NV_WR, p});
        wb(~d, 1'b1);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        sr({CMD_STORE, 5'h00});
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        chk({7'h0, busy}, 8'h00);
        sr({CMD_WPROT, 5'h00});
        wb(8'hFE, 1'b0);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        chk({7'h0, wp}, 8'h00);
        sr({CMD_STORE, 5'h00});
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        nv[0] = m_wip;
        poll();
        sr({CMD_WIPER_WR, 5'h00});
        wb(8'(m_wip ^ 255), 1'b0);
        sr({CMD_RESTORE, 5'h00});
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        m_wip = nv[0];
        chk(wip, 8'(m_wip));
        sr({CMD_NV_RD, p});
        adr(1'b1, 1'b0);
        rb(8'(nv[p]), 1'b1);
        sr({CMD_TOL_RD, PTR_TOL_INT});
        adr(1'b1, 1'b0);
        rb(TI, 1'b0);
        rb(TF, 1'b1);
        sr({CMD_TOL_RD, PTR_TOL_FRAC});
        adr(1'b1, 1'b0);
        rb(TF, 1'b1);
        sr({CMD_WIPER_RD, 5'h00});
        adr(1'b1, 1'b0);
        rb(8'(m_wip), 1'b1);
        pscp_master_inst.cond(1'b1, 1'b0, 1'b1);
        chk({7'h0, sdo}, 8'h00);
        wrap_up();
    end
endmodule : pot_serial_command_port_tb_top
